// ===== design/bwac_top.sv
// Bus controller wait-state, access-state and upper address control registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Wait mode 00 programmable, 01 no controller waits, 10 pin wait, 11 auto-wait.
// - Wait count codes 00 to 11 insert zero to three wait states.
// - Count 00 or mode 01 means the controller adds no wait states.
// - Eight area wait enable bits, read/write, reset to one, enable per area.
// - Operating mode field read-only, taken from the three mode pins.
// - Upper address bits 7..5: 0 gives address output, 1 gives general I/O.
// - Upper bits reset 1, writable only in mode 3; bit 0 resets 0, always writable.
// - Access state bit 0 gives two-state area, 1 three-state; all reset to one.
// - Wait control resets mode 00, count 11, upper four bits read one.
module bwac_top #(
   parameter int AREAS = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Avalon-MM register slave
   input wire logic [bwac_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [bwac_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [bwac_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Mode pins
   input wire logic [2:0] mode_pin,
   // External access cycle
   input wire logic acc_start,
   input wire logic [2:0] acc_area,
   input wire logic wait_pin_n,
   output logic acc_busy,
   output logic acc_wait,
   output logic acc_end,
   output logic acc_three_state,
   // Upper address pin function, 1 drives address
   output logic addr23_out_enable,
   output logic addr22_out_enable,
   output logic addr21_out_enable,
   output logic [2:0] opmode
);
   generate
      if (AREAS != 8) begin : g_bad_areas
         $error("bwac_top: AREAS must be 8");
      end
   endgenerate

   function automatic logic hit(input logic [bwac_pkg::ADDR_W-1:0] addr,
                                input logic [7:0] idx);
      hit = (addr == {idx, 2'h0});
   endfunction : hit

   // Pin synchronisers; first stage feeds only the second
   logic [2:0] mode_s1_ff, mode_s2_ff;
   logic wait_s1_ff, wait_s2_ff;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_mode_sync
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               mode_s1_ff[gi] <= 1'b0;
               mode_s2_ff[gi] <= 1'b0;
            end else begin
               mode_s1_ff[gi] <= mode_pin[gi];
               mode_s2_ff[gi] <= mode_s1_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wait_s1_ff <= 1'b1;
         wait_s2_ff <= 1'b1;
      end else begin
         wait_s1_ff <= wait_pin_n;
         wait_s2_ff <= wait_s1_ff;
      end
   end

   // Mode straps are latched once after release, then held
   logic [1:0] cap_cnt_ff, nxt_cap_cnt;
   logic [2:0] mode_ff, nxt_mode;

   always_comb begin
      nxt_cap_cnt = cap_cnt_ff;
      nxt_mode = mode_ff;
      if (cap_cnt_ff != 2'h3) begin
         nxt_cap_cnt = cap_cnt_ff + 2'h1;
      end
      if (cap_cnt_ff == bwac_pkg::MODE_CAPTURE_AT) begin
         nxt_mode = mode_s2_ff;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cap_cnt_ff <= 2'h0;
         mode_ff <= bwac_pkg::RST_OPMODE;
      end else begin
         cap_cnt_ff <= nxt_cap_cnt;
         mode_ff <= nxt_mode;
      end
   end

   // Register bus: one wait cycle per access
   logic ack_ff, nxt_ack;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [7:0] ast_ff, nxt_ast;
   logic [3:0] wctl_ff, nxt_wctl;
   logic [7:0] wen_ff, nxt_wen;
   logic [2:0] ua_ff, nxt_ua;
   logic ua0_ff, nxt_ua0;
   logic req, wr_take;
   logic [7:0] wd;
   logic [7:0] rd_val;

   assign req = avs_read || avs_write;
   assign wr_take = avs_write && ack_ff && avs_byteenable[0];
   assign wd = avs_writedata[7:0];

   always_comb begin
      rd_val = 8'h00;
      if (hit(avs_address, bwac_pkg::IDX_ACCESS_STATE)) begin
         rd_val = ast_ff;
      end else if (hit(avs_address, bwac_pkg::IDX_WAIT_CTRL)) begin
         rd_val = bwac_pkg::WAIT_CTRL_ONES | {4'h0, wctl_ff};
      end else if (hit(avs_address, bwac_pkg::IDX_WAIT_EN)) begin
         rd_val = wen_ff;
      end else if (hit(avs_address, bwac_pkg::IDX_OPMODE)) begin
         rd_val = bwac_pkg::OPMODE_FIXED | {5'h00, mode_ff};
      end else if (hit(avs_address, bwac_pkg::IDX_UPPER_ADDR)) begin
         rd_val = bwac_pkg::UPPER_ADDR_ONES | {ua_ff, 4'h0, ua0_ff};
      end
   end

   always_comb begin
      nxt_ack = req && !ack_ff;
      nxt_rdata = rdata_ff;
      nxt_ast = ast_ff;
      nxt_wctl = wctl_ff;
      nxt_wen = wen_ff;
      nxt_ua = ua_ff;
      nxt_ua0 = ua0_ff;
      if (avs_read && !ack_ff) begin
         nxt_rdata = rd_val;
      end
      if (wr_take) begin
         if (hit(avs_address, bwac_pkg::IDX_ACCESS_STATE)) begin
            nxt_ast = wd;
         end
         if (hit(avs_address, bwac_pkg::IDX_WAIT_CTRL)) begin
            nxt_wctl = wd[3:0];
         end
         if (hit(avs_address, bwac_pkg::IDX_WAIT_EN)) begin
            nxt_wen = wd;
         end
         if (hit(avs_address, bwac_pkg::IDX_UPPER_ADDR)) begin
            nxt_ua0 = wd[bwac_pkg::UA_BIT0];
            if (mode_ff == bwac_pkg::OPM_3) begin
               nxt_ua = wd[bwac_pkg::UA_LSB +: 3];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ack_ff <= 1'b0;
         rdata_ff <= 8'h00;
         ast_ff <= bwac_pkg::RST_ACCESS_STATE;
         wctl_ff <= bwac_pkg::RST_WAIT_CTRL[3:0];
         wen_ff <= bwac_pkg::RST_WAIT_EN;
         ua_ff <= bwac_pkg::RST_UPPER_ADDR[bwac_pkg::UA_LSB +: 3];
         ua0_ff <= bwac_pkg::RST_UPPER_ADDR[bwac_pkg::UA_BIT0];
      end else begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
         ast_ff <= nxt_ast;
         wctl_ff <= nxt_wctl;
         wen_ff <= nxt_wen;
         ua_ff <= nxt_ua;
         ua0_ff <= nxt_ua0;
      end
   end

   assign avs_waitrequest = req && !ack_ff;
   assign avs_readdata = {24'h000000, rdata_ff};

   // Wait-state selection for a new access cycle
   logic [1:0] wmode, wcount;
   logic area_en, area_3st, pin_low;
   logic [1:0] wait_num;
   logic pin_ext;

   assign wmode = wctl_ff[bwac_pkg::WMS_LSB +: 2];
   assign wcount = wctl_ff[bwac_pkg::WC_LSB +: 2];
   assign area_en = wen_ff[acc_area];
   assign area_3st = ast_ff[acc_area];
   assign pin_low = !wait_s2_ff;

   always_comb begin
      wait_num = 2'h0;
      pin_ext = 1'b0;
      if (!area_en) begin
         pin_ext = 1'b1;
      end else begin
         case (wmode)
            bwac_pkg::WM_PROG: begin
               wait_num = wcount;
            end
            bwac_pkg::WM_NONE: begin
               wait_num = 2'h0;
            end
            bwac_pkg::WM_PIN1: begin
               wait_num = wcount;
               pin_ext = 1'b1;
            end
            bwac_pkg::WM_AUTO: begin
               // Auto-wait inserts the count only when the pin asks at cycle start
               wait_num = pin_low ? wcount : 2'h0;
            end
            default: begin
               wait_num = 2'h0;
            end
         endcase
      end
   end

   bwac_wait_seq u_seq (
      .clock(clock),
      .nrst(nrst),
      .start(acc_start),
      .three_state(area_3st),
      .wait_num(wait_num),
      .pin_ext(pin_ext),
      .pin_low(pin_low),
      .busy(acc_busy),
      .wait_state(acc_wait),
      .cycle_end(acc_end)
   );

   // Pin function outputs
   assign acc_three_state = area_3st;
   assign addr23_out_enable = !ua_ff[2];
   assign addr22_out_enable = !ua_ff[1];
   assign addr21_out_enable = !ua_ff[0];
   assign opmode = mode_ff;
endmodule : bwac_top
`default_nettype wire

// ===== design/bwac_wait_seq.sv
// Access cycle sequencer: base states, inserted waits, pin-held waits
`timescale 1ns/1ps
`default_nettype none
module bwac_wait_seq (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Cycle request and area settings, sampled only while idle; pin level sampled during the cycle
   input wire logic start,
   input wire logic three_state,
   input wire logic [1:0] wait_num,
   input wire logic pin_ext,
   input wire logic pin_low,
   // Cycle status
   output logic busy,
   output logic wait_state,
   output logic cycle_end
);
   bwac_pkg::bwac_seq_t state_ff, nxt_state;
   logic [1:0] cnt_ff, nxt_cnt;
   logic [1:0] wn_ff, nxt_wn;
   logic ext_ff, nxt_ext;
   logic end_ff, nxt_end;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_wn = wn_ff;
      nxt_ext = ext_ff;
      nxt_end = 1'b0;
      case (state_ff)
         bwac_pkg::ST_IDLE: begin
            if (start) begin
               nxt_cnt = three_state ? bwac_pkg::BASE3_LEN : bwac_pkg::BASE2_LEN;
               nxt_wn = wait_num;
               nxt_ext = pin_ext;
               nxt_state = bwac_pkg::ST_BASE;
            end
         end
         bwac_pkg::ST_BASE: begin
            if (cnt_ff != 2'h0) begin
               nxt_cnt = cnt_ff - 2'h1;
            end else if (wn_ff != 2'h0) begin
               nxt_cnt = wn_ff - 2'h1;
               nxt_state = bwac_pkg::ST_WAIT;
            end else if (ext_ff && pin_low) begin
               nxt_state = bwac_pkg::ST_HOLD;
            end else begin
               nxt_end = 1'b1;
               nxt_state = bwac_pkg::ST_IDLE;
            end
         end
         bwac_pkg::ST_WAIT: begin
            if (cnt_ff != 2'h0) begin
               nxt_cnt = cnt_ff - 2'h1;
            end else if (ext_ff && pin_low) begin
               nxt_state = bwac_pkg::ST_HOLD;
            end else begin
               nxt_end = 1'b1;
               nxt_state = bwac_pkg::ST_IDLE;
            end
         end
         bwac_pkg::ST_HOLD: begin
            if (!pin_low) begin
               nxt_end = 1'b1;
               nxt_state = bwac_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = bwac_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff <= bwac_pkg::ST_IDLE;
         cnt_ff <= 2'h0;
         wn_ff <= 2'h0;
         ext_ff <= 1'b0;
         end_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         wn_ff <= nxt_wn;
         ext_ff <= nxt_ext;
         end_ff <= nxt_end;
      end
   end

   assign busy = (state_ff != bwac_pkg::ST_IDLE);
   assign wait_state = (state_ff == bwac_pkg::ST_WAIT) || (state_ff == bwac_pkg::ST_HOLD);
   assign cycle_end = end_ff;
endmodule : bwac_wait_seq
`default_nettype wire

// ===== pkg/bwac_pkg.sv
// Constants and types shared by the bus wait-state and address control block
`default_nettype none
package bwac_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_ACCESS_STATE = 8'hED;
   localparam logic [7:0] IDX_WAIT_CTRL = 8'hEE;
   localparam logic [7:0] IDX_WAIT_EN = 8'hEF;
   localparam logic [7:0] IDX_OPMODE = 8'hF1;
   localparam logic [7:0] IDX_UPPER_ADDR = 8'hF3;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // Reset values
   localparam logic [7:0] RST_ACCESS_STATE = 8'hFF;
   localparam logic [7:0] RST_WAIT_CTRL = 8'hF3;
   localparam logic [7:0] RST_WAIT_EN = 8'hFF;
   localparam logic [7:0] RST_UPPER_ADDR = 8'hFE;
   localparam logic [2:0] RST_OPMODE = 3'h0;

   // Fixed bits of partly read-only registers
   localparam logic [7:0] WAIT_CTRL_ONES = 8'hF0;
   localparam logic [7:0] OPMODE_FIXED = 8'hC0;
   localparam logic [7:0] UPPER_ADDR_ONES = 8'h1E;

   // Field positions
   localparam int WMS_LSB = 2;
   localparam int WC_LSB = 0;
   localparam int UA_LSB = 5;
   localparam int UA_BIT0 = 0;

   // Wait mode codes
   localparam logic [1:0] WM_PROG = 2'h0;
   localparam logic [1:0] WM_NONE = 2'h1;
   localparam logic [1:0] WM_PIN1 = 2'h2;
   localparam logic [1:0] WM_AUTO = 2'h3;

   // Operating mode codes
   localparam logic [2:0] OPM_1 = 3'h1;
   localparam logic [2:0] OPM_3 = 3'h3;
   localparam logic [2:0] OPM_5 = 3'h5;
   localparam logic [2:0] OPM_6 = 3'h6;
   localparam logic [2:0] OPM_7 = 3'h7;

   // Cycle after reset release at which the synchronised mode pins are latched
   localparam logic [1:0] MODE_CAPTURE_AT = 2'h2;

   // Access cycle lengths in states, minus one
   localparam logic [1:0] BASE2_LEN = 2'h1;
   localparam logic [1:0] BASE3_LEN = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_BASE = 4'h2,
      ST_WAIT = 4'h4,
      ST_HOLD = 4'h8
   } bwac_seq_t;
endpackage : bwac_pkg
`default_nettype wire

// ===== tb/bwac_checker.sv
// Assertions on bus handshake, access cycle and pin outputs
`timescale 1ns/1ps
`default_nettype none
module bwac_checker (
   // Watched top-level ports
   input wire logic clock,
   input wire logic nrst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic acc_start,
   input wire logic acc_busy,
   input wire logic acc_wait,
   input wire logic acc_end,
   input wire logic addr23_out_enable,
   input wire logic [2:0] opmode
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_one_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
   property p_addr_hold;
      !$past(avs_write) && !$past(avs_write, 2) |-> $stable(addr23_out_enable);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("pin enable moved without write");
   property p_ua_locked;
      opmode != 3'h3 |=> $stable(addr23_out_enable);
   endproperty
   a_ua_locked: assert property (p_ua_locked) else $error("upper enable moved outside mode 3");
   property p_opmode_once;
      $past(opmode) != 3'h0 |-> opmode == $past(opmode);
   endproperty
   a_opmode_once: assert property (p_opmode_once) else $error("mode changed after latch");
   property p_start_busy;
      acc_start && !acc_busy |=> acc_busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("cycle did not start");
   property p_min_len;
      acc_start && !acc_busy |=> !acc_end [*2];
   endproperty
   a_min_len: assert property (p_min_len) else $error("cycle shorter than base");
   property p_end_pulse;
      acc_end |-> !acc_busy ##1 !acc_end;
   endproperty
   a_end_pulse: assert property (p_end_pulse) else $error("end not a single pulse");
   property p_end_cause;
      acc_end |-> $past(acc_busy);
   endproperty
   a_end_cause: assert property (p_end_cause) else $error("end without cycle");
   property p_wait_busy;
      acc_wait |-> acc_busy;
   endproperty
   a_wait_busy: assert property (p_wait_busy) else $error("wait outside cycle");
endmodule : bwac_checker
bind bwac_top bwac_checker u_chk (.clock(clock), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .acc_start(acc_start),
   .acc_busy(acc_busy), .acc_wait(acc_wait), .acc_end(acc_end),
   .addr23_out_enable(addr23_out_enable), .opmode(opmode));
`default_nettype wire

// ===== tb/bwac_ext_mem.sv
// Slow external device model that holds the wait pin low
`timescale 1ns/1ps
`default_nettype none
module bwac_ext_mem #(
   parameter int HOLD = 6
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Cycle status and stall command
   input wire logic acc_busy,
   input wire logic slow,
   output logic wait_pin_n
);
   logic [3:0] cnt_ff;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) cnt_ff <= 4'h0;
      else if (!acc_busy) cnt_ff <= 4'h0;
      else if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
   end
   // Released pin is driven high by the model
   assign wait_pin_n = !(slow && 32'(cnt_ff) < HOLD);
endmodule : bwac_ext_mem
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the wait-state and address control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock, nrst, rd, wr, start, slow, wreq, busy, wt, done, ts, e23, e22, e21;
   logic [9:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [3:0] be;
   logic [2:0] mode_pin, area, opm;
   int mismatches, checks;
   int nw;
   wire logic wpn;
   bwac_top dut (.clock(clock), .nrst(nrst), .avs_address(addr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .mode_pin(mode_pin), .acc_start(start), .acc_area(area),
      .wait_pin_n(wpn), .acc_busy(busy), .acc_wait(wt), .acc_end(done),
      .acc_three_state(ts), .addr23_out_enable(e23), .addr22_out_enable(e22),
      .addr21_out_enable(e21), .opmode(opm));
   bwac_ext_mem ext (.clock(clock), .nrst(nrst), .acc_busy(busy), .slow(slow),
      .wait_pin_n(wpn));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge clock);
      addr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      rd <= !w;
      wr <= w;
      n = 0;
      // Waitrequest judged at the rising edge, where the write lands and data is taken
      do begin
         @(posedge clock);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (wreq !== 1'b0) begin
         mismatches++;
         wrap_up();
      end
   endtask : bus
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(q, {24'h0, exp});
   endtask : rchk
   task automatic do_reset(input logic [2:0] m);
      @(posedge clock);
      nrst <= 1'b0;
      mode_pin <= m;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      repeat (5) @(posedge clock);
   endtask : do_reset
   task automatic acc_run(input logic [2:0] a, input int exp, input logic longer);
      int n;
      @(posedge clock);
      area <= a;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      n = 1;
      nw = 0;
      while (n < 60) begin
         @(negedge clock);
         if (wt === 1'b1) nw++;
         if (done === 1'b1) break;
         @(posedge clock);
         n++;
      end
      if (longer) check(32'(n > exp), 32'h1);
      else check(n, exp);
   endtask : acc_run
   initial begin
      nrst = 1'b0;
      {rd, wr, start, slow} = 4'h0;
      addr = 10'h000;
      wdata = 32'h0;
      be = 4'hF;
      area = 3'h0;
      mode_pin = 3'h3;
      mismatches = 0;
      checks = 0;
      do_reset(3'h3);
      rchk(bwac_pkg::IDX_ACCESS_STATE, 8'hFF);
      rchk(bwac_pkg::IDX_WAIT_CTRL, 8'hF3);
      rchk(bwac_pkg::IDX_WAIT_EN, 8'hFF);
      rchk(bwac_pkg::IDX_OPMODE, 8'hC3);
      rchk(bwac_pkg::IDX_UPPER_ADDR, 8'hFE);
      rchk(8'h00, 8'h00);
      check({e23, e22, e21}, 32'h0);
      bus(1'b1, bwac_pkg::IDX_UPPER_ADDR, 8'h41);
      rchk(bwac_pkg::IDX_UPPER_ADDR, 8'h5F);
      check({e23, e22, e21}, 32'h5);
      $display("test reset and mode 3 done");
      be <= 4'hE;
      bus(1'b1, bwac_pkg::IDX_WAIT_EN, 8'h00);
      be <= 4'hF;
      rchk(bwac_pkg::IDX_WAIT_EN, 8'hFF);
      bus(1'b1, bwac_pkg::IDX_WAIT_EN, 8'hFE);
      rchk(bwac_pkg::IDX_WAIT_EN, 8'hFE);
      bus(1'b1, bwac_pkg::IDX_ACCESS_STATE, 8'hFD);
      rchk(bwac_pkg::IDX_ACCESS_STATE, 8'hFD);
      // Two-state area with waits enabled, pin idle then stalling
      for (int s = 0; s < 2; s++) begin
         for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 4; c++) begin
               int w;
               slow <= s[0];
               bus(1'b1, bwac_pkg::IDX_WAIT_CTRL, {4'h0, m[1:0], c[1:0]});
               w = (m == 1 || (m == 3 && s == 0)) ? 0 : c;
               acc_run(3'h1, 3 + w, s == 1 && m == 2);
            end
         end
      end
      rchk(bwac_pkg::IDX_WAIT_CTRL, 8'hFF);
      slow <= 1'b0;
      bus(1'b1, bwac_pkg::IDX_WAIT_CTRL, 8'h03);
      acc_run(3'h0, 4, 1'b0);
      check(nw, 32'h0);
      check(ts, 32'h1);
      acc_run(3'h1, 6, 1'b0);
      check(nw, 32'h3);
      // Disabled area still stretches the cycle while the pin is held low
      @(posedge clock);
      slow <= 1'b1;
      acc_run(3'h0, 4, 1'b1);
      check(32'(nw > 0), 32'h1);
      slow <= 1'b0;
      $display("test access cycles done");
      do_reset(3'h1);
      check(opm, 32'h1);
      rchk(bwac_pkg::IDX_OPMODE, 8'hC1);
      bus(1'b1, bwac_pkg::IDX_UPPER_ADDR, 8'h01);
      rchk(bwac_pkg::IDX_UPPER_ADDR, 8'hFF);
      bus(1'b1, bwac_pkg::IDX_UPPER_ADDR, 8'h00);
      rchk(bwac_pkg::IDX_UPPER_ADDR, 8'hFE);
      check({e23, e22, e21}, 32'h0);
      $display("test mode 1 done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
